// file: mspm_pkg.sv
// Shared constants and types for the meter serial-mode and pulse block
package mspm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned MCLK_HZ          = 25_000_000;
  localparam int unsigned SAMPLE_DIV_LOG2  = 8;        // New result every 256 clocks
  localparam int unsigned ENTRY_WINDOW_US  = 10_000;   // Mode entry window after reset
  localparam int unsigned ENTRY_WINDOW_CYC = ENTRY_WINDOW_US * (MCLK_HZ / 1_000_000);
  localparam int unsigned PULSE_WIDTH_NS   = 800;      // Pulse output high time
  localparam int unsigned PULSE_CYC        = (PULSE_WIDTH_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DR_CYC           = 4;        // Ready marker low time

  // ****************************************
  // Data widths and coding
  // ****************************************
  localparam int unsigned ADC_W  = 16;
  localparam int unsigned MULT_W = 20;
  localparam int unsigned WORD_W = 32;
  localparam logic signed [ADC_W-1:0]  ADC_MAX  = 16'h7fff;
  localparam logic signed [ADC_W-1:0]  ADC_MIN  = 16'h8000;
  localparam logic signed [MULT_W-1:0] MULT_MAX = 20'h7ffff;
  localparam logic signed [MULT_W-1:0] MULT_MIN = 20'h80000;
  localparam int unsigned HPF_SHIFT  = 10;
  localparam int unsigned LPF_SHIFT  = 6;
  localparam int unsigned PROD_SHIFT = 11;

  // ****************************************
  // Pulse constants and no-load level
  // ****************************************
  localparam int unsigned FULL_SCALE_LOG2 = 19;
  localparam logic [4:0]  FC_LOG2_BASE    = 5'h15;  // 21, minus the two low select bits
  localparam logic [4:0]  HFC_LOG2_SLOW   = 5'h0f;  // 15
  localparam logic [4:0]  HFC_LOG2_FAST   = 5'h07;  // 7
  localparam logic [4:0]  HFC_LOG2_HI     = 5'h10;  // 16
  localparam logic [2:0]  FSEL_NO_CREEP   = 3'h3;   // Select code without suppression
  localparam int unsigned NOLOAD_PPM      = 15;     // 0.0015 percent
  localparam int unsigned NOLOAD_MIN      = ((1 << FULL_SCALE_LOG2) * NOLOAD_PPM + 999_999) / 1_000_000;

  // ****************************************
  // Entry commands
  // ****************************************
  localparam logic [7:0] CMD_MULT_0  = 8'ha1;
  localparam logic [7:0] CMD_MULT_1  = 8'ha9;
  localparam logic [7:0] CMD_DUAL_PRE  = 8'ha4;
  localparam logic [7:0] CMD_DUAL_POST = 8'hac;
  localparam logic [7:0] CMD_FILT_0  = 8'haa;
  localparam logic [7:0] CMD_FILT_1  = 8'hae;
  localparam logic [7:0] CMD_FILT_2  = 8'ha2;
  localparam logic [7:0] CMD_FILT_3  = 8'ha6;
  localparam int unsigned CMD_HI_BIT  = 3;
  localparam int unsigned CMD_MID_BIT = 2;

  typedef enum logic [2:0] {
    MSPM_MODE_NONE,
    MSPM_MODE_MULT,
    MSPM_MODE_DUAL_PRE,
    MSPM_MODE_DUAL_POST,
    MSPM_MODE_FILTER
  } mspm_mode_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  OFFS_CONFIG    = 8'h00;
  localparam logic [7:0]  OFFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFFS_MULT_WORD = 8'h08;
  localparam logic [1:0]  CONFIG_RST     = 2'h0;
  localparam int unsigned CFG_GAIN_LSB   = 0;
  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_FSEL_LSB    = 4;
  localparam int unsigned ST_NEG_BIT     = 8;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

endpackage : mspm_pkg

// file: mspm_dtf.sv
// Energy accumulator that turns filtered power into output pulses
module mspm_dtf (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic signed [19:0] i_power,
  input  wire logic [4:0]         i_log2_div,
  input  wire logic               i_noload_off,
  output logic                    o_pulse
);

  logic [20:0] mag;
  logic [41:0] thr;
  logic [41:0] acc_r;
  logic [41:0] acc_sum;
  logic        active;
  logic        fire;
  logic [7:0]  pw_r;

  // ****************************************
  // Accumulate and compare
  // ****************************************
  // Full-scale power advances one threshold per 2^div clocks
  always_comb begin
    mag     = i_power[19] ? 21'(-22'(i_power)) : 21'(i_power);
    thr     = 42'h1 << (mspm_pkg::FULL_SCALE_LOG2 + 32'(i_log2_div));
    active  = i_noload_off | (mag >= 21'(mspm_pkg::NOLOAD_MIN));
    acc_sum = acc_r + 42'(mag);
    fire    = active & (acc_sum >= thr);
  end

  // Below no-load the sum is frozen unless i_noload_off is set, so creep then never reaches a pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      acc_r <= '0;
    end else if (fire) begin
      acc_r <= acc_sum - thr;
    end else if (active) begin
      acc_r <= acc_sum;
    end
  end

  // ****************************************
  // Pulse stretch
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pw_r    <= '0;
      o_pulse <= 1'b0;
    end else begin
      if (fire) begin
        pw_r <= 8'(mspm_pkg::PULSE_CYC);
      end else if (pw_r != 8'h0) begin
        pw_r <= pw_r - 8'h1;
      end
      o_pulse <= fire | (pw_r > 8'h1);
    end
  end

endmodule : mspm_dtf

// file: mspm_top.sv
// Serial mode entry, multiplier readout and energy pulse outputs of the meter
module mspm_top #(
  parameter int unsigned ENTRY_WINDOW_CYC = mspm_pkg::ENTRY_WINDOW_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_external_clear_n,
  input  wire logic        i_highpass_enable_pin,
  input  wire logic [15:0] i_ch0_data,
  input  wire logic [15:0] i_ch1_data,
  input  wire logic        i_rate_select_hi,
  input  wire logic        i_rate_select_mid,
  input  wire logic        i_rate_select_lo,
  output logic             o_negative_power_flag,
  output logic             o_energy_pulse_a,
  output logic             o_energy_pulse_b,
  output logic             o_calibration_pulse_out,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                        rst;
  logic [7:0]                  div_r;
  logic                        tick;
  logic                        tick_q_r;
  logic signed [15:0]          adc [2];
  logic signed [15:0]          adc_r [2];
  logic signed [25:0]          dc_r [2];
  logic signed [15:0]          hp_r [2];
  logic signed [35:0]          prod;
  logic signed [19:0]          mult_r;
  logic signed [19:0]          fin_r;
  logic signed [19:0]          lpf_in;
  logic signed [25:0]          lpf_r;
  logic signed [19:0]          power;
  logic                        neg;
  logic [1:0]                  gain_r;
  mspm_pkg::mspm_mode_t        mode_r;
  logic [7:0]                  cmd_r;
  logic [2:0]                  fsel;
  logic [4:0]                  lo_div;
  logic [4:0]                  hi_div;
  logic                        noload_off;
  logic                        low_pulse;
  logic                        sck_prev_r;
  logic                        cs_prev_r;
  logic                        sck_rise;
  logic                        sck_fall;
  logic                        cs_n;
  logic [31:0]                 win_r;
  logic [7:0]                  ent_sh_r;
  logic [3:0]                  ent_cnt_r;
  logic [7:0]                  ent_code;
  logic [31:0]                 word_r;
  logic [31:0]                 tx_r;
  logic [19:0]                 rx_r;
  logic [4:0]                  rx_cnt_r;
  logic [2:0]                  dr_cnt_r;
  logic                        aw_take;
  logic                        ar_take;

  // Clear pin and system reset both restart the block and the entry window
  assign rst = i_sys_rst | ~i_external_clear_n;

  function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
    if (v > 17'(mspm_pkg::ADC_MAX)) begin
      return mspm_pkg::ADC_MAX;
    end else if (v < 17'(mspm_pkg::ADC_MIN)) begin
      return mspm_pkg::ADC_MIN;
    end
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [19:0] sat20(input logic signed [35:0] v);
    if (v > 36'(mspm_pkg::MULT_MAX)) begin
      return mspm_pkg::MULT_MAX;
    end else if (v < 36'(mspm_pkg::MULT_MIN)) begin
      return mspm_pkg::MULT_MIN;
    end
    return v[19:0];
  endfunction : sat20

  // ****************************************
  // Sample timebase
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      div_r    <= '0;
      tick_q_r <= 1'b0;
    end else begin
      div_r    <= div_r + 8'h1;
      tick_q_r <= tick;
    end
  end
  assign tick = (div_r == 8'((1 << mspm_pkg::SAMPLE_DIV_LOG2) - 1));

  // ****************************************
  // Channel high-pass filters
  // ****************************************
  assign adc[0] = i_ch0_data;
  assign adc[1] = i_ch1_data;

  // Leaky DC estimate; pin low passes raw samples through
  for (genvar g = 0; g < 2; g++) begin : g_chan
    always_ff @(posedge i_ref_clk) begin
      if (rst) begin
        dc_r[g]  <= '0;
        adc_r[g] <= '0;
        hp_r[g]  <= '0;
      end else if (tick) begin
        dc_r[g]  <= dc_r[g] + 26'(adc[g]) - (dc_r[g] >>> mspm_pkg::HPF_SHIFT);
        adc_r[g] <= adc[g];
        hp_r[g]  <= i_highpass_enable_pin
                    ? sat16(17'(adc[g]) - 17'(16'(dc_r[g] >>> mspm_pkg::HPF_SHIFT)))
                    : adc[g];
      end
    end
  end

  // ****************************************
  // Multiplier and power low-pass
  // ****************************************
  assign prod = (36'(hp_r[0]) * 36'(hp_r[1])) <<< gain_r;

  // Filter input mode replaces the product feeding the low-pass
  assign lpf_in = (mode_r == mspm_pkg::MSPM_MODE_FILTER) ? fin_r : mult_r;
  assign power  = 20'(lpf_r >>> mspm_pkg::LPF_SHIFT);
  assign neg    = power[19];

  // Energy path runs in every mode
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      mult_r <= '0;
      lpf_r  <= '0;
    end else if (tick) begin
      mult_r <= sat20(prod >>> mspm_pkg::PROD_SHIFT);
      lpf_r  <= lpf_r + 26'(lpf_in) - (lpf_r >>> mspm_pkg::LPF_SHIFT);
    end
  end

  // ****************************************
  // Frequency select and pulse outputs
  // ****************************************
  // Serial modes take select bits from command and live pins; multiplier and dual modes tie the low bit high
  always_comb begin
    case (mode_r)
      mspm_pkg::MSPM_MODE_NONE: begin
        fsel = {i_rate_select_hi, i_rate_select_mid, i_rate_select_lo};
      end
      mspm_pkg::MSPM_MODE_FILTER: begin
        fsel = {cmd_r[mspm_pkg::CMD_HI_BIT], cmd_r[mspm_pkg::CMD_MID_BIT], i_rate_select_lo};
      end
      default: begin
        fsel = {cmd_r[mspm_pkg::CMD_HI_BIT], i_rate_select_mid, 1'b1};
      end
    endcase
  end

  always_comb begin
    lo_div = mspm_pkg::FC_LOG2_BASE - {3'h0, fsel[1:0]};
    if (fsel[2]) begin
      hi_div = mspm_pkg::HFC_LOG2_HI;
    end else if (fsel[1:0] == 2'h3) begin
      hi_div = mspm_pkg::HFC_LOG2_FAST;
    end else begin
      hi_div = mspm_pkg::HFC_LOG2_SLOW;
    end
    noload_off = (fsel == mspm_pkg::FSEL_NO_CREEP);
  end

  // Both low-rate outputs share one accumulator; threshold scales with constant
  mspm_dtf u_low_rate (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (rst),
    .i_power      (power),
    .i_log2_div   (lo_div),
    .i_noload_off (noload_off),
    .o_pulse      (low_pulse)
  );

  mspm_dtf u_high_rate (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (rst),
    .i_power      (power),
    .i_log2_div   (hi_div),
    .i_noload_off (noload_off),
    .o_pulse      (o_calibration_pulse_out)
  );

  assign o_energy_pulse_a = low_pulse;
  assign o_energy_pulse_b = low_pulse;

  // ****************************************
  // Serial pin edges and entry window
  // ****************************************
  // Pins are synchronous, so the clock must run well above the serial clock
  assign cs_n     = i_rate_select_lo;
  assign sck_rise = i_rate_select_hi & ~sck_prev_r;
  assign sck_fall = ~i_rate_select_hi & sck_prev_r;
  assign ent_code = {ent_sh_r[6:0], i_rate_select_mid};

  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
      win_r      <= 32'(ENTRY_WINDOW_CYC);
    end else begin
      sck_prev_r <= i_rate_select_hi;
      cs_prev_r  <= cs_n;
      if (win_r != 32'h0) begin
        win_r <= win_r - 32'h1;
      end
    end
  end

  // ****************************************
  // Mode entry decoder
  // ****************************************
  // Unknown codes are dropped; once set only reset clears the mode
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      mode_r    <= mspm_pkg::MSPM_MODE_NONE;
      cmd_r     <= '0;
      ent_sh_r  <= '0;
      ent_cnt_r <= '0;
    end else if (mode_r == mspm_pkg::MSPM_MODE_NONE) begin
      if (cs_n || win_r == 32'h0) begin
        ent_cnt_r <= '0;
      end else if (sck_rise) begin
        ent_sh_r  <= ent_code;
        ent_cnt_r <= (ent_cnt_r == 4'h7) ? 4'h0 : ent_cnt_r + 4'h1;
        if (ent_cnt_r == 4'h7) begin
          cmd_r <= ent_code;
          case (ent_code)
            mspm_pkg::CMD_MULT_0, mspm_pkg::CMD_MULT_1: begin
              mode_r <= mspm_pkg::MSPM_MODE_MULT;
            end
            mspm_pkg::CMD_DUAL_PRE: begin
              mode_r <= mspm_pkg::MSPM_MODE_DUAL_PRE;
            end
            mspm_pkg::CMD_DUAL_POST: begin
              mode_r <= mspm_pkg::MSPM_MODE_DUAL_POST;
            end
            mspm_pkg::CMD_FILT_0, mspm_pkg::CMD_FILT_1,
            mspm_pkg::CMD_FILT_2, mspm_pkg::CMD_FILT_3: begin
              mode_r <= mspm_pkg::MSPM_MODE_FILTER;
            end
            default: begin
              mode_r <= mspm_pkg::MSPM_MODE_NONE;
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // Result word, ready marker and shift-out
  // ****************************************
  // Each new result overwrites the held word whether read or not
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      word_r   <= '0;
      dr_cnt_r <= '0;
    end else if (tick_q_r) begin
      dr_cnt_r <= 3'(mspm_pkg::DR_CYC);
      case (mode_r)
        mspm_pkg::MSPM_MODE_DUAL_PRE: begin
          word_r <= {adc_r[1], adc_r[0]};
        end
        mspm_pkg::MSPM_MODE_DUAL_POST: begin
          word_r <= i_highpass_enable_pin ? {hp_r[1], hp_r[0]} : 32'h0;
        end
        default: begin
          word_r <= {mult_r, 12'h0};
        end
      endcase
    end else if (dr_cnt_r != 3'h0) begin
      dr_cnt_r <= dr_cnt_r - 3'h1;
    end
  end

  // Word is captured at select fall, then shifted on falling serial clock
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      tx_r <= '0;
    end else if (cs_prev_r && !cs_n) begin
      tx_r <= word_r;
    end else if (!cs_n && sck_fall) begin
      tx_r <= {tx_r[30:0], 1'b0};
    end
  end

  // Filter input: 20 bits MSB first, sampled on rising serial clock
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      rx_r     <= '0;
      rx_cnt_r <= '0;
      fin_r    <= '0;
    end else if (mode_r != mspm_pkg::MSPM_MODE_FILTER || cs_n) begin
      rx_cnt_r <= '0;
    end else if (sck_rise) begin
      rx_r     <= {rx_r[18:0], i_rate_select_mid};
      rx_cnt_r <= (rx_cnt_r == 5'(mspm_pkg::MULT_W - 1)) ? 5'h0 : rx_cnt_r + 5'h1;
      if (rx_cnt_r == 5'(mspm_pkg::MULT_W - 1)) begin
        fin_r <= {rx_r[18:0], i_rate_select_mid};
      end
    end
  end

  // Shared pin: power flag before entry; afterwards serial data out while selected outside filter mode, else ready marker
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      o_negative_power_flag <= 1'b0;
    end else if (mode_r == mspm_pkg::MSPM_MODE_NONE) begin
      o_negative_power_flag <= neg;
    end else if (!cs_n && mode_r != mspm_pkg::MSPM_MODE_FILTER) begin
      o_negative_power_flag <= tx_r[31];
    end else begin
      o_negative_power_flag <= (dr_cnt_r == 3'h0);
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Address and data are taken together, one write in flight
  assign aw_take         = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  assign o_s_axi_awready = aw_take;
  assign o_s_axi_wready  = aw_take;
  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign ar_take         = i_s_axi_arvalid & ~o_s_axi_rvalid;

  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      gain_r         <= mspm_pkg::CONFIG_RST;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= mspm_pkg::RESP_OKAY;
    end else if (aw_take) begin
      o_s_axi_bvalid <= 1'b1;
      if (i_s_axi_awaddr == mspm_pkg::OFFS_CONFIG) begin
        o_s_axi_bresp <= mspm_pkg::RESP_OKAY;
        if (i_s_axi_wstrb[0]) begin
          gain_r <= i_s_axi_wdata[mspm_pkg::CFG_GAIN_LSB +: 2];
        end
      end else begin
        o_s_axi_bresp <= mspm_pkg::RESP_DECERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // Status shows mode, live select code and sign of power
  always_ff @(posedge i_ref_clk) begin
    if (rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= '0;
      o_s_axi_rresp  <= mspm_pkg::RESP_OKAY;
    end else if (ar_take) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= mspm_pkg::RESP_OKAY;
      o_s_axi_rdata  <= '0;
      case (i_s_axi_araddr)
        mspm_pkg::OFFS_CONFIG: begin
          o_s_axi_rdata[mspm_pkg::CFG_GAIN_LSB +: 2] <= gain_r;
        end
        mspm_pkg::OFFS_STATUS: begin
          o_s_axi_rdata[mspm_pkg::ST_MODE_LSB +: 3] <= mode_r;
          o_s_axi_rdata[mspm_pkg::ST_FSEL_LSB +: 3] <= fsel;
          o_s_axi_rdata[mspm_pkg::ST_NEG_BIT]       <= neg;
        end
        mspm_pkg::OFFS_MULT_WORD: begin
          o_s_axi_rdata <= 32'(mult_r);
        end
        default: begin
          o_s_axi_rresp <= mspm_pkg::RESP_DECERR;
        end
      endcase
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule : mspm_top

// file: mspm_props.sv
// Port checker for the meter serial-mode block
module mspm_props (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_external_clear_n,
  input wire logic [7:0]  i_s_axi_araddr,
  input wire logic        i_s_axi_arvalid,
  input wire logic        i_s_axi_awvalid,
  input wire logic        i_s_axi_wvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_rready,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_bvalid,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_rvalid,
  input wire logic [1:0]  o_s_axi_rresp,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_energy_pulse_a,
  input wire logic        o_energy_pulse_b,
  input wire logic        o_calibration_pulse_out,
  input wire logic        o_negative_power_flag
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst || !i_external_clear_n);
  // Bus answers one cycle after taking, held until accepted
  rst_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_s_axi_bvalid && !o_s_axi_rvalid)
    else $error("bus responses not cleared by reset");
  wr_answer_a: assert property (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid |=> o_s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered");
  wr_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  rd_retire_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read response not retired");
  bad_addr_a: assert property (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == 8'h0c
    |=> o_s_axi_rresp == mspm_pkg::RESP_DECERR && o_s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Low-rate outputs are one pulse train; the calibration pulse has a minimum width
  pulse_pair_a: assert property (o_energy_pulse_a == o_energy_pulse_b)
    else $error("low-rate outputs differ");
  cal_width_a: assert property ($rose(o_calibration_pulse_out) |-> o_calibration_pulse_out [*8])
    else $error("calibration pulse too short");
  wr_seen_c: cover property (i_s_axi_awvalid && i_s_axi_wvalid);
  cal_seen_c: cover property ($rose(o_calibration_pulse_out));
  mark_seen_c: cover property ($fell(o_negative_power_flag));
endmodule : mspm_props

bind mspm_top mspm_props i_props (.*);

// file: mspm_host.sv
// Serial host model driving the shared select pins
module mspm_host (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdi_idle = 1'b0; // Data-in level left between frames
  // Clock parked low and select high outside frames
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_cs_n = 1'b1;
  end
  // Eight reference clocks a bit, far below the serial clock limit
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    @(posedge i_ref_clk) o_cs_n <= 1'b0;
    for (int b = n - 1; b >= 0; b--) begin
      o_sdi <= tx[b];
      repeat (4) @(posedge i_ref_clk);
      o_sck <= 1'b1;
      rx = {rx[30:0], i_sdo};
      repeat (4) @(posedge i_ref_clk);
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    o_sdi <= sdi_idle;
  endtask : xfer
endmodule : mspm_host

// file: testbench.sv
// Self-checking bench for the meter serial-mode block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, clr_n, hp, awv, wv, bry, arv, rry;
  logic        awr, wr, bv, arr, rv, neg, pa, pb, cal, sck, sdi, cs_n;
  logic [15:0] ch0, ch1;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, q, rx;
  logic [1:0]  br, rr, resp;
  int          bad_count = 0, checks_done = 0, cyc = 0, n;
  logic [7:0]  cmds [9] = '{mspm_pkg::CMD_MULT_0, mspm_pkg::CMD_MULT_1, mspm_pkg::CMD_DUAL_PRE,
    mspm_pkg::CMD_DUAL_POST, mspm_pkg::CMD_FILT_0, mspm_pkg::CMD_FILT_1, mspm_pkg::CMD_FILT_2,
    mspm_pkg::CMD_FILT_3, mspm_pkg::CMD_MULT_0};
  logic [7:0]  exps [9] = '{8'h11, 8'h51, 8'h12, 8'h53, 8'h54, 8'h74, 8'h14, 8'h34, 8'h10};
  mspm_top #(.ENTRY_WINDOW_CYC(200)) i_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_external_clear_n(clr_n), .i_highpass_enable_pin(hp),
    .i_ch0_data(ch0), .i_ch1_data(ch1), .i_rate_select_hi(sck), .i_rate_select_mid(sdi),
    .i_rate_select_lo(cs_n), .o_negative_power_flag(neg), .o_energy_pulse_a(pa), .o_energy_pulse_b(pb),
    .o_calibration_pulse_out(cal), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry));
  mspm_host i_host (.i_ref_clk(clk), .i_sdo(neg), .o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n));
  // Clock and hang guard, well above the expected few thousand cycles
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Address and data offered together; bready held until the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, d, 3'h7};
    do @(posedge clk); while (awr !== 1'b1);
    {awv, wv} <= 2'h0;
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'h3};
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rd;
    resp = rr;
    rry <= 1'b0;
  endtask : axi_rd
  task automatic clear_pin;
    @(posedge clk) clr_n <= 1'b0;
    @(posedge clk) clr_n <= 1'b1;
  endtask : clear_pin
  // Main sequence: bus, entry codes, then multiplier readout
  initial begin
    {rst, clr_n, hp, awv, wv, bry, arv, rry, awa, ara, wd} = {2'h3, 6'h0, 48'h0};
    {ch0, ch1} = {16'h7fff, 16'h7fff};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    axi_rd(8'h0c, q);
    chk({q[31:2], resp}, {30'h0, mspm_pkg::RESP_DECERR});
    for (int i = 0; i < 9; i++) begin
      clear_pin;
      if (i == 8) repeat (250) @(posedge clk);
      i_host.xfer({24'h0, cmds[i]}, 8, rx);
      axi_rd(mspm_pkg::OFFS_STATUS, q);
      chk(q & 32'h77, {24'h0, exps[i]});
    end
    clear_pin;
    i_host.xfer({24'h0, mspm_pkg::CMD_MULT_1}, 8, rx);
    i_host.xfer({24'h0, mspm_pkg::CMD_DUAL_PRE}, 8, rx);
    i_host.sdi_idle = 1'b1;
    i_host.o_sdi <= 1'b1;
    axi_rd(mspm_pkg::OFFS_STATUS, q);
    chk(q & 32'h77, 32'h71);
    axi_wr(mspm_pkg::OFFS_CONFIG, 32'h3);
    // Start from the idle level so a marker already under way is not counted short
    do @(posedge clk); while (neg !== 1'b1);
    do @(posedge clk); while (neg !== 1'b0);
    n = 0;
    do begin @(posedge clk); n++; end while (neg === 1'b0);
    chk(n, mspm_pkg::DR_CYC);
    do begin @(posedge clk); n++; end while (neg !== 1'b0);
    chk(n, 256);
    for (int k = 0; k < 2; k++) begin
      ch1 <= k ? 16'h8000 : 16'h7fff;
      repeat (600) @(posedge clk);
      axi_rd(mspm_pkg::OFFS_MULT_WORD, q);
      chk(q, k ? 32'hfff80000 : 32'h0007ffff);
      i_host.xfer(32'h0, 32, rx);
      chk(rx, k ? 32'h80000000 : 32'h7ffff000);
    end
    // Plain select pins at 011: fastest high-rate constant, no creep gate
    clear_pin;
    n = 0;
    do begin @(posedge clk); n++; end while (cal !== 1'b1 && n < 4000);
    chk(cal, 1'b1);
    axi_rd(mspm_pkg::OFFS_STATUS, q);
    chk(q & 32'h177, 32'h130);
    final_report;
  end
endmodule : testbench
